// File: hdl/lsim_pkg.sv
// constants and register map of the load-switch interrupt masking block
// What this block does
// - the load-switch mask register sits at index 0x4 and clears to zero on reset.
// - mask bits 5, 4 and 3 are writable fault masks of the high-voltage, 5 V and low-voltage switch.
// - mask bits 2, 1 and 0 are writable current-limit masks of the same three switches.
// - a clear mask bit lets its event pull the active-low interrupt output low.
// - a set mask bit keeps its event from pulling the interrupt output low.
// - events are captured and monitored whatever the masks say; masks gate only the output.
// - bit 0 of the preceding mask register masks the power-good comparator event the same way.
package lsim_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] PG_MASK_IDX = 8'h03;
    localparam logic [7:0] LS_MASK_IDX = 8'h04;
    localparam logic [7:0] STATUS_IDX = 8'h08;
    localparam logic [7:0] LIVE_IDX = 8'h09;
    localparam logic [7:0] PG_MASK_ADDR = {PG_MASK_IDX[5:0], 2'b00};
    localparam logic [7:0] LS_MASK_ADDR = {LS_MASK_IDX[5:0], 2'b00};
    localparam logic [7:0] STATUS_ADDR = {STATUS_IDX[5:0], 2'b00};
    localparam logic [7:0] LIVE_ADDR = {LIVE_IDX[5:0], 2'b00};
    // reset values
    localparam logic [5:0] LS_MASK_RST = 6'h00;
    localparam logic PG_MASK_RST = 1'b0;
    localparam logic [6:0] STATUS_RST = 7'h00;
    // event and mask bit positions
    localparam int unsigned NUM_EVT = 7;
    localparam int unsigned LS_FIELD_W = 6;
    localparam int unsigned LOWV_ILIM_BIT = 0;
    localparam int unsigned FIVE_ILIM_BIT = 1;
    localparam int unsigned HV_ILIM_BIT = 2;
    localparam int unsigned LOWV_FAULT_BIT = 3;
    localparam int unsigned FIVE_FAULT_BIT = 4;
    localparam int unsigned HV_FAULT_BIT = 5;
    localparam int unsigned PG_EVT_BIT = 6;
    localparam int unsigned PG_MASK_BIT = 0;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : lsim_pkg

// File: hdl/lsim_sync.sv
// two-flop synchroniser for asynchronous event levels
`timescale 1ns/10ps
module lsim_sync #(
    parameter int unsigned W = 7
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= din;
            stage2 <= stage1;
        end
    end

    assign dout = stage2;
endmodule : lsim_sync

// File: hdl/lsim_axil_slave.sv
// AXI4-Lite slave front end turning bus traffic into register strobes
`timescale 1ns/10ps
module lsim_axil_slave #(
    parameter int unsigned AW = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [AW-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // read address and data
    input wire logic arvalid,
    output logic arready,
    input wire logic [AW-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // register side
    output logic wr_req,
    output logic [AW-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic rd_req,
    output logic [AW-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
    logic aw_full, next_aw_full;
    logic w_full, next_w_full;
    logic [AW-1:0] aw_q, next_aw_q;
    logic [31:0] w_q, next_w_q;
    logic [3:0] s_q, next_s_q;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;

    assign awready = !aw_full && !bvalid;
    assign wready = !w_full && !bvalid;
    assign arready = !rvalid;
    // write fires once address and data are both held
    assign wr_req = aw_full && w_full;
    assign wr_addr = aw_q;
    assign wr_data = w_q;
    assign wr_strb = s_q;
    assign rd_req = arvalid && arready;
    assign rd_addr = araddr;

    always_comb begin
        next_aw_full = aw_full;
        next_w_full = w_full;
        next_aw_q = aw_q;
        next_w_q = w_q;
        next_s_q = s_q;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        if (awvalid && awready) begin
            next_aw_full = 1'b1;
            next_aw_q = awaddr;
        end
        if (wvalid && wready) begin
            next_w_full = 1'b1;
            next_w_q = wdata;
            next_s_q = wstrb;
        end
        if (wr_req) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_ok ? lsim_pkg::RESP_OKAY : lsim_pkg::RESP_SLVERR;
        end else if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (rd_req) begin
            next_rvalid = 1'b1;
            next_rdata = rd_data;
            next_rresp = rd_ok ? lsim_pkg::RESP_OKAY : lsim_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_q <= '0;
            w_q <= 32'h00000000;
            s_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= lsim_pkg::RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= lsim_pkg::RESP_OKAY;
            rdata <= 32'h00000000;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            aw_q <= next_aw_q;
            w_q <= next_w_q;
            s_q <= next_s_q;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
        end
    end
endmodule : lsim_axil_slave

// File: hdl/lsim_top.sv
// load-switch interrupt masking: mask registers, sticky status and interrupt pin
`timescale 1ns/10ps
module lsim_top (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // AXI4-Lite write address and data
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    // AXI4-Lite write response
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    output logic [1:0] S_AXI_BRESP,
    // AXI4-Lite read
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    // load-switch and comparator event levels, active high
    input wire logic HV_LOAD_SWITCH_FAULT,
    input wire logic FIVE_VOLT_LOAD_SWITCH_FAULT,
    input wire logic LOWV_LOAD_SWITCH_FAULT,
    input wire logic HV_LOAD_SWITCH_ILIM,
    input wire logic FIVE_VOLT_LOAD_SWITCH_ILIM,
    input wire logic LOWV_LOAD_SWITCH_ILIM,
    input wire logic POWER_GOOD_CMP_EVENT,
    // interrupt to the host
    output logic IRQ_OUT_N
);
    localparam int unsigned NE = lsim_pkg::NUM_EVT;

    ////////////////////////////////////////////////////////////////////////////////
    // reset release

    logic rst_meta;
    logic rst_n;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // event capture

    logic [NE-1:0] evt_raw;
    logic [NE-1:0] evt_s;

    assign evt_raw[lsim_pkg::LOWV_ILIM_BIT] = LOWV_LOAD_SWITCH_ILIM;
    assign evt_raw[lsim_pkg::FIVE_ILIM_BIT] = FIVE_VOLT_LOAD_SWITCH_ILIM;
    assign evt_raw[lsim_pkg::HV_ILIM_BIT] = HV_LOAD_SWITCH_ILIM;
    assign evt_raw[lsim_pkg::LOWV_FAULT_BIT] = LOWV_LOAD_SWITCH_FAULT;
    assign evt_raw[lsim_pkg::FIVE_FAULT_BIT] = FIVE_VOLT_LOAD_SWITCH_FAULT;
    assign evt_raw[lsim_pkg::HV_FAULT_BIT] = HV_LOAD_SWITCH_FAULT;
    assign evt_raw[lsim_pkg::PG_EVT_BIT] = POWER_GOOD_CMP_EVENT;

    lsim_sync #(
        .W(NE)
    ) u_sync (
        .clk(MCLK),
        .rst_n(rst_n),
        .din(evt_raw),
        .dout(evt_s)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // bus front end

    logic wr_req, wr_ok, rd_req, rd_ok;
    logic [7:0] wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0] wr_strb;

    lsim_axil_slave #(
        .AW(8)
    ) u_bus (
        .clk(MCLK),
        .rst_n(rst_n),
        .awvalid(S_AXI_AWVALID),
        .awready(S_AXI_AWREADY),
        .awaddr(S_AXI_AWADDR),
        .wvalid(S_AXI_WVALID),
        .wready(S_AXI_WREADY),
        .wdata(S_AXI_WDATA),
        .wstrb(S_AXI_WSTRB),
        .bvalid(S_AXI_BVALID),
        .bready(S_AXI_BREADY),
        .bresp(S_AXI_BRESP),
        .arvalid(S_AXI_ARVALID),
        .arready(S_AXI_ARREADY),
        .araddr(S_AXI_ARADDR),
        .rvalid(S_AXI_RVALID),
        .rready(S_AXI_RREADY),
        .rdata(S_AXI_RDATA),
        .rresp(S_AXI_RRESP),
        .wr_req(wr_req),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_req(rd_req),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // register file

    logic [lsim_pkg::LS_FIELD_W-1:0] ls_mask, next_ls_mask;
    logic pg_mask, next_pg_mask;
    logic [NE-1:0] status, next_status;
    logic [NE-1:0] eff_mask;
    logic irq_n, next_irq_n;
    logic wr_ls, wr_pg, wr_st, lane0;

    assign lane0 = wr_strb[0];
    assign wr_ls = wr_req && (wr_addr == lsim_pkg::LS_MASK_ADDR);
    assign wr_pg = wr_req && (wr_addr == lsim_pkg::PG_MASK_ADDR);
    assign wr_st = wr_req && (wr_addr == lsim_pkg::STATUS_ADDR);
    assign wr_ok = (wr_addr == lsim_pkg::LS_MASK_ADDR)
                || (wr_addr == lsim_pkg::PG_MASK_ADDR)
                || (wr_addr == lsim_pkg::STATUS_ADDR)
                || (wr_addr == lsim_pkg::LIVE_ADDR);
    assign eff_mask = {pg_mask, ls_mask};

    always_comb begin
        next_ls_mask = ls_mask;
        next_pg_mask = pg_mask;
        // reserved bits 7:6 never reach storage
        if (wr_ls && lane0) begin
            next_ls_mask = wr_data[lsim_pkg::LS_FIELD_W-1:0];
        end
        if (wr_pg && lane0) begin
            next_pg_mask = wr_data[lsim_pkg::PG_MASK_BIT];
        end
        // capture ignores masks; set wins over clear
        next_status = status;
        if (wr_st && lane0) begin
            next_status = status & ~wr_data[NE-1:0];
        end
        next_status = next_status | evt_s;
        // unmasked pending status pulls the pin low
        next_irq_n = ~|(status & ~eff_mask);
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            ls_mask <= lsim_pkg::LS_MASK_RST;
            pg_mask <= lsim_pkg::PG_MASK_RST;
            status <= lsim_pkg::STATUS_RST;
            irq_n <= 1'b1;
        end else begin
            ls_mask <= next_ls_mask;
            pg_mask <= next_pg_mask;
            status <= next_status;
            irq_n <= next_irq_n;
        end
    end

    assign IRQ_OUT_N = irq_n;

    always_comb begin
        rd_data = 32'h00000000;
        rd_ok = 1'b1;
        unique case (rd_addr)
            lsim_pkg::LS_MASK_ADDR: rd_data[lsim_pkg::LS_FIELD_W-1:0] = ls_mask;
            lsim_pkg::PG_MASK_ADDR: rd_data[lsim_pkg::PG_MASK_BIT] = pg_mask;
            lsim_pkg::STATUS_ADDR: rd_data[NE-1:0] = status;
            lsim_pkg::LIVE_ADDR: rd_data[NE-1:0] = evt_s;
            default: rd_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!rst_n);

    sequence s_unmasked_evt(int b);
        evt_s[b] && !eff_mask[b];
    endsequence

    sequence s_pin_low;
        !irq_n ##1 1'b1;
    endsequence

    property p_reset_clear;
        $rose(rst_n) |-> (ls_mask == 6'h00) && !pg_mask && irq_n;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("mask registers not clear after reset");

    property p_fault_mask_wr;
        wr_ls && lane0 |=> ls_mask[5:3] == $past(wr_data[5:3]);
    endproperty
    a_fault_mask_wr: assert property (p_fault_mask_wr)
        else $error("fault mask bits did not take the written value");

    property p_ilim_mask_wr;
        wr_ls && lane0 |=> ls_mask[2:0] == $past(wr_data[2:0]);
    endproperty
    a_ilim_mask_wr: assert property (p_ilim_mask_wr)
        else $error("current-limit mask bits did not take the written value");

    property p_unmasked_pulls_low;
        (s_unmasked_evt(lsim_pkg::HV_FAULT_BIT) or s_unmasked_evt(lsim_pkg::LOWV_ILIM_BIT))
            ##1 !eff_mask[lsim_pkg::HV_FAULT_BIT] && !eff_mask[lsim_pkg::LOWV_ILIM_BIT]
            |=> s_pin_low;
    endproperty
    a_unmasked_pulls_low: assert property (p_unmasked_pulls_low)
        else $error("unmasked event did not pull the interrupt low");

    property p_masked_no_effect;
        ((status & ~eff_mask) == 7'h00) |=> irq_n;
    endproperty
    a_masked_no_effect: assert property (p_masked_no_effect)
        else $error("interrupt low with no unmasked status pending");

    property p_monitor_always;
        (|evt_s) |=> ((status & $past(evt_s)) == $past(evt_s));
    endproperty
    a_monitor_always: assert property (p_monitor_always)
        else $error("event not captured in status");

    property p_pg_mask_wr;
        wr_pg && lane0 |=> pg_mask == $past(wr_data[lsim_pkg::PG_MASK_BIT]);
    endproperty
    a_pg_mask_wr: assert property (p_pg_mask_wr)
        else $error("power-good mask bit did not take the written value");

    property p_pg_unmasked;
        s_unmasked_evt(lsim_pkg::PG_EVT_BIT) ##1 !pg_mask |=> s_pin_low;
    endproperty
    a_pg_unmasked: assert property (p_pg_unmasked)
        else $error("unmasked power-good event did not pull the interrupt low");

    property p_reserved_zero;
        rd_req && rd_addr == lsim_pkg::LS_MASK_ADDR |=> S_AXI_RDATA[31:6] == 26'h0000000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved mask bits read non-zero");

    property p_wr_answer;
        wr_req |=> S_AXI_BVALID;
    endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("write response did not follow the register write");

    property p_rd_answer;
        rd_req |=> S_AXI_RVALID;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read data did not follow the read address");

    property p_bvalid_hold;
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold)
        else $error("write response dropped before it was taken");

    property p_rvalid_hold;
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    a_rvalid_hold: assert property (p_rvalid_hold)
        else $error("read data dropped before it was taken");

    property p_rd_unmapped;
        rd_req && !rd_ok |=> S_AXI_RRESP == lsim_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h00000000;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read not answered with an error and zero data");

    // per event: pin follows unmasked status, capture and clear ignore masks
    for (genvar g = 0; g < NE; g++) begin : g_evt_chk
        property p_evt_unmasked;
            s_unmasked_evt(g) ##1 !eff_mask[g] |=> s_pin_low;
        endproperty
        a_evt_unmasked: assert property (p_evt_unmasked)
            else $error("unmasked event did not pull the interrupt low");

        property p_evt_captured;
            evt_s[g] |=> status[g];
        endproperty
        a_evt_captured: assert property (p_evt_captured)
            else $error("event bit not captured in status");

        property p_status_w1c;
            wr_st && lane0 && wr_data[g] && !evt_s[g] |=> !status[g];
        endproperty
        a_status_w1c: assert property (p_status_w1c)
            else $error("status bit not cleared by a one written to it");
    end
endmodule : lsim_top

// File: verification/lsim_host_model.sv
// host model: watches the interrupt line and counts requests
`timescale 1ns/10ps
module lsim_host_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // interrupt line
    input wire logic irq_out_n,
    output logic irq_seen,
    output logic [15:0] n_irq
);
    logic last_n;
    logic next_last_n;
    logic [15:0] next_n_irq;
    // one request per falling edge of the line
    always_comb begin
        next_last_n = irq_out_n;
        next_n_irq = n_irq;
        if (last_n && !irq_out_n) begin
            next_n_irq = n_irq + 16'h0001;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_n <= 1'b1;
            n_irq <= 16'h0000;
        end else begin
            last_n <= next_last_n;
            n_irq <= next_n_irq;
        end
    end
    assign irq_seen = !irq_out_n;
endmodule : lsim_host_model

// File: verification/lsim_tb_top.sv
// bench for the load-switch interrupt masking block
`timescale 1ns/10ps
module lsim_tb_top;
    logic MCLK = 1'b0;
    logic RST_N = 1'b0;
    logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
    logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
    logic [31:0] S_AXI_WDATA = 32'h0;
    logic [3:0] S_AXI_WSTRB = 4'h0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, IRQ_OUT_N;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic [31:0] S_AXI_RDATA;
    logic [6:0] evt = 7'h00;
    logic irq_seen;
    logic [15:0] n_irq;
    int n_mismatch = 0;
    int num_checks = 0;
    always #4 MCLK = ~MCLK;
    lsim_top i_dut (
        .MCLK, .RST_N, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_AWADDR, .S_AXI_WVALID,
        .S_AXI_WREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP,
        .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_ARADDR, .S_AXI_RVALID, .S_AXI_RREADY,
        .S_AXI_RDATA, .S_AXI_RRESP,
        .HV_LOAD_SWITCH_FAULT(evt[5]),
        .FIVE_VOLT_LOAD_SWITCH_FAULT(evt[4]),
        .LOWV_LOAD_SWITCH_FAULT(evt[3]),
        .HV_LOAD_SWITCH_ILIM(evt[2]),
        .FIVE_VOLT_LOAD_SWITCH_ILIM(evt[1]),
        .LOWV_LOAD_SWITCH_ILIM(evt[0]),
        .POWER_GOOD_CMP_EVENT(evt[6]),
        .IRQ_OUT_N
    );
    lsim_host_model i_host (
        .clk(MCLK), .rst_n(RST_N), .irq_out_n(IRQ_OUT_N), .irq_seen(irq_seen), .n_irq(n_irq)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    // address and data offered together, each released once taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw_ok;
        bit w_ok;
        bit b_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        b_ok = 1'b0;
        @(posedge MCLK);
        S_AXI_AWADDR <= a;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WDATA <= d;
        S_AXI_WSTRB <= 4'hf;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        while (!b_ok) begin
            @(posedge MCLK);
            if (!aw_ok && S_AXI_AWREADY) begin
                aw_ok = 1'b1;
                S_AXI_AWVALID <= 1'b0;
            end
            if (!w_ok && S_AXI_WREADY) begin
                w_ok = 1'b1;
                S_AXI_WVALID <= 1'b0;
            end
            if (S_AXI_BVALID) begin
                b_ok = 1'b1;
                r = S_AXI_BRESP;
                S_AXI_BREADY <= 1'b0;
            end
        end
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ar_ok;
        bit r_ok;
        ar_ok = 1'b0;
        r_ok = 1'b0;
        @(posedge MCLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        while (!r_ok) begin
            @(posedge MCLK);
            if (!ar_ok && S_AXI_ARREADY) begin
                ar_ok = 1'b1;
                S_AXI_ARVALID <= 1'b0;
            end
            if (S_AXI_RVALID) begin
                r_ok = 1'b1;
                d = S_AXI_RDATA;
                r = S_AXI_RRESP;
                S_AXI_RREADY <= 1'b0;
            end
        end
    endtask : axi_read
    task automatic drive_evt(input logic [6:0] v);
        @(posedge MCLK);
        evt <= v;
    endtask : drive_evt
    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (IRQ_OUT_N !== lvl && n < 20) begin
            @(posedge MCLK);
            n++;
        end
        // let registered outputs settle before they are compared
        @(negedge MCLK);
    endtask : wait_irq
    task automatic set_mask(input int i, input logic on);
        logic [1:0] r;
        if (i < 6) begin
            axi_write(lsim_pkg::LS_MASK_ADDR, on ? (32'h1 << i) : 32'h0, r);
        end else begin
            axi_write(lsim_pkg::PG_MASK_ADDR, {31'h0, on}, r);
        end
    endtask : set_mask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        logic [31:0] d;
        logic [1:0] r;
        axi_read(lsim_pkg::LS_MASK_ADDR, d, r);
        check(d, 32'h0);
        check(32'(r), 32'(lsim_pkg::RESP_OKAY));
        axi_read(lsim_pkg::PG_MASK_ADDR, d, r);
        check(d, 32'h0);
        axi_read(lsim_pkg::STATUS_ADDR, d, r);
        check(d, 32'h0);
        check(32'(IRQ_OUT_N), 32'h1);
        axi_read(8'hfc, d, r);
        check(32'(r), 32'(lsim_pkg::RESP_SLVERR));
        check(d, 32'h0);
        $display("test_reset done");
    endtask : test_reset
    task automatic test_mask_rw();
        logic [31:0] d;
        logic [1:0] r;
        axi_write(lsim_pkg::LS_MASK_ADDR, 32'hffffffff, r);
        check(32'(r), 32'(lsim_pkg::RESP_OKAY));
        axi_read(lsim_pkg::LS_MASK_ADDR, d, r);
        check(d, 32'h3f);
        axi_write(lsim_pkg::LS_MASK_ADDR, 32'h2a, r);
        axi_read(lsim_pkg::LS_MASK_ADDR, d, r);
        check(d, 32'h2a);
        axi_write(lsim_pkg::LS_MASK_ADDR, 32'hd5, r);
        axi_read(lsim_pkg::LS_MASK_ADDR, d, r);
        check(d, 32'h15);
        axi_write(lsim_pkg::PG_MASK_ADDR, 32'hfffffffe, r);
        axi_read(lsim_pkg::PG_MASK_ADDR, d, r);
        check(d, 32'h0);
        axi_write(lsim_pkg::PG_MASK_ADDR, 32'h1, r);
        axi_read(lsim_pkg::PG_MASK_ADDR, d, r);
        check(d, 32'h1);
        axi_write(8'hfc, 32'h1, r);
        check(32'(r), 32'(lsim_pkg::RESP_SLVERR));
        axi_write(lsim_pkg::LS_MASK_ADDR, 32'h0, r);
        axi_write(lsim_pkg::PG_MASK_ADDR, 32'h0, r);
        $display("test_mask_rw done");
    endtask : test_mask_rw
    // every event unmasked, then masked, then unmasked while still pending
    task automatic test_events();
        logic [31:0] d;
        logic [1:0] r;
        logic [6:0] v;
        logic [15:0] cnt;
        for (int i = 0; i < 7; i++) begin
            v = 7'h01 << i;
            cnt = n_irq;
            drive_evt(v);
            wait_irq(1'b0);
            check(32'(IRQ_OUT_N), 32'h0);
            check(32'(n_irq), 32'(cnt + 16'h1));
            check(32'(irq_seen), 32'h1);
            drive_evt(7'h00);
            axi_read(lsim_pkg::STATUS_ADDR, d, r);
            check(d, 32'(v));
            axi_write(lsim_pkg::STATUS_ADDR, 32'(v), r);
            wait_irq(1'b1);
            check(32'(IRQ_OUT_N), 32'h1);
            set_mask(i, 1'b1);
            cnt = n_irq;
            drive_evt(v);
            repeat (8) @(posedge MCLK);
            check(32'(IRQ_OUT_N), 32'h1);
            check(32'(n_irq), 32'(cnt));
            check(32'(irq_seen), 32'h0);
            axi_read(lsim_pkg::LIVE_ADDR, d, r);
            check(d, 32'(v));
            axi_read(lsim_pkg::STATUS_ADDR, d, r);
            check(d, 32'(v));
            // clear while the event still stands: the set wins
            axi_write(lsim_pkg::STATUS_ADDR, 32'(v), r);
            axi_read(lsim_pkg::STATUS_ADDR, d, r);
            check(d, 32'(v));
            set_mask(i, 1'b0);
            wait_irq(1'b0);
            check(32'(IRQ_OUT_N), 32'h0);
            check(32'(n_irq), 32'(cnt + 16'h1));
            drive_evt(7'h00);
            axi_write(lsim_pkg::STATUS_ADDR, 32'(v), r);
            wait_irq(1'b1);
            check(32'(IRQ_OUT_N), 32'h1);
        end
        $display("test_events done");
    endtask : test_events
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge MCLK);
        RST_N <= 1'b1;
        repeat (3) @(posedge MCLK);
        test_reset();
        test_mask_rw();
        test_events();
        print_verdict();
    end
    // hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge MCLK);
        n_mismatch++;
        print_verdict();
    end
endmodule : lsim_tb_top
